// ---- slpem_checker.sv ----
/*
  Checker of the register port between the host end and the device end.
  Assumes the bench instantiates it beside the interface on one clock.
*/
`default_nettype none
module slpem_checker
    import slpem_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] smp_q, smp_d, den_q, den_d, chk_q, chk_d, dsk_q, dsk_d, sel_q, sel_d;
    always_comb begin
        smp_d = (wr_en && addr == SLPEM_ADDR_SAMPLES) ? wdata : smp_q;
        den_d = (wr_en && addr == SLPEM_ADDR_DENSITY) ? wdata : den_q;
        chk_d = (wr_en && addr == SLPEM_ADDR_CHECKSUM) ? wdata : chk_q;
        dsk_d = (wr_en && addr == SLPEM_ADDR_DESKEW) ? wdata : dsk_q;
        sel_d = (wr_en && addr == SLPEM_ADDR_ERRMON) ? wdata : sel_q;
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            smp_q <= SLPEM_RST_SAMPLES;
            den_q <= SLPEM_RST_DENSITY;
            chk_q <= SLPEM_RST_CHECKSUM;
            dsk_q <= SLPEM_RST_DESKEW;
            sel_q <= 8'h00;
        end else begin
            smp_q <= smp_d;
            den_q <= den_d;
            chk_q <= chk_d;
            dsk_q <= dsk_d;
            sel_q <= sel_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_read_answer: assert property (rd_en |=> rvalid)
        else $error("read strobe not answered");
    a_rvalid_cause: assert property (rvalid |-> $past(rd_en))
        else $error("read valid without read strobe");
    a_samples_back: assert property (rd_en && addr == SLPEM_ADDR_SAMPLES
        |=> rdata == smp_q)
        else $error("samples register readback wrong");
    a_density_back: assert property (rd_en && addr == SLPEM_ADDR_DENSITY
        |=> rdata == den_q)
        else $error("density register readback wrong");
    a_checksum_back: assert property (rd_en && addr == SLPEM_ADDR_CHECKSUM
        |=> rdata == chk_q)
        else $error("checksum register readback wrong");
    a_deskew_back: assert property (rd_en && addr == SLPEM_ADDR_DESKEW |=> rdata == dsk_q)
        else $error("deskew register readback wrong");
    a_kind_unused: assert property (rd_en && addr == SLPEM_ADDR_ERRMON
        && sel_q[1:0] == 2'h3 |=> rdata == 8'h00)
        else $error("unused counter kind read nonzero");
    a_write_pulse: assert property (wr_en |=> !wr_en)
        else $error("write strobe longer than one cycle");
endmodule // slpem_checker
`default_nettype wire

// ---- slpem_device.sv ----
/*
  Device end: link parameter registers, error counters, disparity flags.
  Assumes error events are one-cycle pulses on clk_sys, one bit per lane.
*/
`default_nettype none
module slpem_device
    import slpem_pkg::*;
#(
    parameter int LANES = SLPEM_LANES
) (
    input wire logic clk_sys,
    input wire logic reset,
    slpem_if.device bus,
    input wire logic [LANES-1:0] disp_err,
    input wire logic [LANES-1:0] nit_err,
    input wire logic [LANES-1:0] ucc_err,
    output logic [LANES-1:0] lane_align_enable,
    output logic [LANES-1:0] disparity_irq,
    output logic checksum_mode,
    output logic [4:0] samples_minus_one
);
    logic [7:0] samples_q, samples_d;
    logic [7:0] density_q, density_d;
    logic [7:0] spare1_q, spare1_d, spare2_q, spare2_d;
    logic [7:0] chk_q, chk_d, deskew_q, deskew_d;
    logic [7:0] thr_q, thr_d, mode_q, mode_d;
    logic [2:0] mon_lane_q, mon_lane_d;
    logic [1:0] mon_kind_q, mon_kind_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [7:0] disp_cnt_q [LANES], disp_cnt_d [LANES];
    logic [7:0] nit_cnt_q [LANES], nit_cnt_d [LANES];
    logic [7:0] ucc_cnt_q [LANES], ucc_cnt_d [LANES];
    logic [LANES-1:0] flags_q, flags_d, stop_q, stop_d;
    logic cmd_wr;
    logic [2:0] cmd_lane;
    logic [7:0] sel_cnt;

    assign cmd_wr = bus.wr_en && bus.addr == SLPEM_ADDR_DISPARITY;
    assign cmd_lane = bus.wdata[2:0];

    always_comb begin
        samples_d = samples_q;
        density_d = density_q;
        spare1_d = spare1_q;
        spare2_d = spare2_q;
        chk_d = chk_q;
        deskew_d = deskew_q;
        thr_d = thr_q;
        mode_d = mode_q;
        mon_lane_d = mon_lane_q;
        mon_kind_d = mon_kind_q;
        if (bus.wr_en) begin
            if (bus.addr == SLPEM_ADDR_SAMPLES) begin
                samples_d = bus.wdata; // [R1]
            end else if (bus.addr == SLPEM_ADDR_DENSITY) begin
                density_d = bus.wdata; // [R2] [R3]
            end else if (bus.addr == SLPEM_ADDR_SPARE1) begin
                spare1_d = bus.wdata;
            end else if (bus.addr == SLPEM_ADDR_SPARE2) begin
                spare2_d = bus.wdata;
            end else if (bus.addr == SLPEM_ADDR_CHECKSUM) begin
                chk_d = bus.wdata; // [R4]
            end else if (bus.addr == SLPEM_ADDR_ERRMON) begin
                mon_lane_d = bus.wdata[SLPEM_SEL_LANE_LSB +: 3]; // [R6]
                mon_kind_d = bus.wdata[1:0]; // [R7]
            end else if (bus.addr == SLPEM_ADDR_DESKEW) begin
                deskew_d = bus.wdata; // [R8]
            end else if (bus.addr == SLPEM_ADDR_THRESHOLD) begin
                thr_d = bus.wdata;
            end else if (bus.addr == SLPEM_ADDR_CHKMODE) begin
                mode_d = bus.wdata;
            end
        end
    end

    always_comb begin
        flags_d = flags_q;
        stop_d = stop_q;
        for (int i = 0; i < LANES; i++) begin
            disp_cnt_d[i] = disp_cnt_q[i];
            nit_cnt_d[i] = nit_cnt_q[i];
            ucc_cnt_d[i] = ucc_cnt_q[i];
            if (disp_err[i] && !stop_q[i] && disp_cnt_q[i] != 8'hFF) begin
                disp_cnt_d[i] = disp_cnt_q[i] + 8'h01;
            end
            if (nit_err[i] && nit_cnt_q[i] != 8'hFF) begin
                nit_cnt_d[i] = nit_cnt_q[i] + 8'h01;
            end
            if (ucc_err[i] && ucc_cnt_q[i] != 8'hFF) begin
                ucc_cnt_d[i] = ucc_cnt_q[i] + 8'h01;
            end
            if (cmd_wr && cmd_lane == i[2:0]) begin
                if (bus.wdata[SLPEM_IRQ_CLR_BIT]) begin
                    flags_d[i] = 1'b0; // [R10] [R13]
                end
                if (bus.wdata[SLPEM_CNT_STOP_BIT]) begin
                    stop_d[i] = 1'b1; // [R11] [R13]
                end
                if (bus.wdata[SLPEM_CNT_CLR_BIT]) begin
                    disp_cnt_d[i] = 8'h00; // [R12] [R13]
                end
            end
            // A threshold hit in the same cycle as a clear leaves the flag set.
            if (disp_cnt_q[i] >= thr_q) begin
                flags_d[i] = 1'b1; // [R9]
            end
        end
    end

    always_comb begin
        sel_cnt = 8'h00;
        if (mon_lane_q < LANES) begin
            case (mon_kind_q)
                SLPEM_KIND_DISP: sel_cnt = disp_cnt_q[mon_lane_q]; // [R5] [R7]
                SLPEM_KIND_NIT: sel_cnt = nit_cnt_q[mon_lane_q];
                SLPEM_KIND_UCC: sel_cnt = ucc_cnt_q[mon_lane_q];
                default: sel_cnt = 8'h00;
            endcase
        end
        rvalid_d = bus.rd_en;
        rdata_d = 8'h00;
        if (bus.rd_en) begin
            if (bus.addr == SLPEM_ADDR_SAMPLES) begin
                rdata_d = samples_q;
            end else if (bus.addr == SLPEM_ADDR_DENSITY) begin
                rdata_d = density_q;
            end else if (bus.addr == SLPEM_ADDR_SPARE1) begin
                rdata_d = spare1_q;
            end else if (bus.addr == SLPEM_ADDR_SPARE2) begin
                rdata_d = spare2_q;
            end else if (bus.addr == SLPEM_ADDR_CHECKSUM) begin
                rdata_d = chk_q;
            end else if (bus.addr == SLPEM_ADDR_ERRMON) begin
                rdata_d = sel_cnt; // [R5]
            end else if (bus.addr == SLPEM_ADDR_DESKEW) begin
                rdata_d = deskew_q;
            end else if (bus.addr == SLPEM_ADDR_DISPARITY) begin
                rdata_d = 8'(flags_q); // [R9]
            end else if (bus.addr == SLPEM_ADDR_THRESHOLD) begin
                rdata_d = thr_q;
            end else if (bus.addr == SLPEM_ADDR_CHKMODE) begin
                rdata_d = mode_q;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            samples_q <= SLPEM_RST_SAMPLES;
            density_q <= SLPEM_RST_DENSITY;
            spare1_q <= SLPEM_RST_SPARE;
            spare2_q <= SLPEM_RST_SPARE;
            chk_q <= SLPEM_RST_CHECKSUM;
            deskew_q <= SLPEM_RST_DESKEW;
            thr_q <= SLPEM_RST_THRESHOLD;
            mode_q <= SLPEM_RST_CHKMODE;
            mon_lane_q <= 3'h0;
            mon_kind_q <= 2'h0;
        end else begin
            samples_q <= samples_d;
            density_q <= density_d;
            spare1_q <= spare1_d;
            spare2_q <= spare2_d;
            chk_q <= chk_d;
            deskew_q <= deskew_d;
            thr_q <= thr_d;
            mode_q <= mode_d;
            mon_lane_q <= mon_lane_d;
            mon_kind_q <= mon_kind_d;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flags_q <= '0;
            stop_q <= '0;
            for (int i = 0; i < LANES; i++) begin
                disp_cnt_q[i] <= 8'h00;
                nit_cnt_q[i] <= 8'h00;
                ucc_cnt_q[i] <= 8'h00;
            end
        end else begin
            flags_q <= flags_d;
            stop_q <= stop_d;
            disp_cnt_q <= disp_cnt_d;
            nit_cnt_q <= nit_cnt_d;
            ucc_cnt_q <= ucc_cnt_d;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.rvalid = rvalid_q;
    assign lane_align_enable = deskew_q[LANES-1:0]; // [R8]
    assign disparity_irq = flags_q;
    assign checksum_mode = mode_q[SLPEM_CHKMODE_BIT]; // [R4]
    assign samples_minus_one = samples_q[4:0];
endmodule // slpem_device
`default_nettype wire

// ---- slpem_host.sv ----
/*
  Host end: performs one register write or read per request.
  Assumes the device answers a read one cycle after the strobe.
*/
`default_nettype none
module slpem_host
    import slpem_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    slpem_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [11:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_busy,
    output logic resp_valid,
    output logic [7:0] resp_data
);
    slpem_host_e state_q, state_d;
    logic wr_q, wr_d, rd_q, rd_d, busy_q, busy_d, rv_q, rv_d;
    logic [11:0] addr_q, addr_d;
    logic [7:0] wd_q, wd_d, rsp_q, rsp_d;

    always_comb begin
        state_d = state_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        rv_d = 1'b0;
        addr_d = addr_q;
        wd_d = wd_q;
        rsp_d = rsp_q;
        busy_d = busy_q;
        case (state_q)
            SLPEM_H_IDLE: begin
                if (req_valid) begin
                    addr_d = req_addr;
                    wd_d = req_wdata;
                    // Density bit and control word field are the caller's duty. [R2] [R3]
                    wr_d = req_write;
                    rd_d = !req_write;
                    busy_d = 1'b1;
                    state_d = req_write ? SLPEM_H_WRITE : SLPEM_H_READ;
                end
            end
            SLPEM_H_WRITE: begin
                busy_d = 1'b0;
                state_d = SLPEM_H_IDLE;
            end
            SLPEM_H_READ: begin
                if (bus.rvalid) begin
                    rsp_d = bus.rdata;
                    rv_d = 1'b1;
                    busy_d = 1'b0;
                    state_d = SLPEM_H_IDLE;
                end
            end
            default: state_d = SLPEM_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= SLPEM_H_IDLE;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rv_q <= 1'b0;
            busy_q <= 1'b0;
            addr_q <= 12'h000;
            wd_q <= 8'h00;
            rsp_q <= 8'h00;
        end else begin
            state_q <= state_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
            busy_q <= busy_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            rsp_q <= rsp_d;
        end
    end

    assign bus.wr_en = wr_q;
    assign bus.rd_en = rd_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wd_q;
    assign req_busy = busy_q;
    assign resp_valid = rv_q;
    assign resp_data = rsp_q;
endmodule // slpem_host
`default_nettype wire

// ---- slpem_if.sv ----
/*
  Register port joining the host end and the device end.
  Assumes both ends share clk_sys; read data is valid one cycle after the read strobe.
*/
`default_nettype none
interface slpem_if;
    logic wr_en;
    logic rd_en;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    modport device (input wr_en, input rd_en, input addr, input wdata,
                    output rdata, output rvalid);
    modport host (output wr_en, output rd_en, output addr, output wdata,
                  input rdata, input rvalid);
endinterface
`default_nettype wire

// ---- slpem_pkg.sv ----
/*
  Package of the serial link parameter and error monitor register slice.
  Assumes an 8-bit register port with a 12-bit address on one clock.
*/
// What this block does
// R1: Five-bit samples-minus-one field, reset zero.
// R2: Host sets density bit from octets per frame; slpem_host passes req_wdata through unchanged.
// R3: Host keeps control words field at zero; slpem_host writes req_wdata unchanged.
// R4: Lane-zero checksum register resets to 0x45.
// R5: Readback returns selected lane error counter.
// R6: Write-only lane index selects readback lane.
// R7: Counter kind 00 disparity, 01 table, 10 control.
// R8: Deskew enable per lane, resets to 0xF.
// R9: Disparity flag sets at count threshold.
// R10: Bit 7 write clears lane disparity interrupt.
// R11: Bit 6 write stops lane disparity counting.
// R12: Bit 5 write clears lane disparity counter.
// R13: Command bits are single pulses, zero ignored.
`default_nettype none
package slpem_pkg;
    localparam int SLPEM_AW = 12;
    localparam int SLPEM_LANES = 8;
    localparam logic [11:0] SLPEM_ADDR_SAMPLES = 12'h459;
    localparam logic [11:0] SLPEM_ADDR_DENSITY = 12'h45A;
    localparam logic [11:0] SLPEM_ADDR_SPARE1 = 12'h45B;
    localparam logic [11:0] SLPEM_ADDR_SPARE2 = 12'h45C;
    localparam logic [11:0] SLPEM_ADDR_CHECKSUM = 12'h45D;
    localparam logic [11:0] SLPEM_ADDR_ERRMON = 12'h46B;
    localparam logic [11:0] SLPEM_ADDR_DESKEW = 12'h46C;
    localparam logic [11:0] SLPEM_ADDR_DISPARITY = 12'h46D;
    localparam logic [11:0] SLPEM_ADDR_THRESHOLD = 12'h47C;
    localparam logic [11:0] SLPEM_ADDR_CHKMODE = 12'h300;
    localparam logic [7:0] SLPEM_RST_SAMPLES = 8'h20;
    localparam logic [7:0] SLPEM_RST_DENSITY = 8'h80;
    localparam logic [7:0] SLPEM_RST_SPARE = 8'h00;
    localparam logic [7:0] SLPEM_RST_CHECKSUM = 8'h45;
    localparam logic [7:0] SLPEM_RST_DESKEW = 8'h0F;
    localparam logic [7:0] SLPEM_RST_THRESHOLD = 8'hFF;
    localparam logic [7:0] SLPEM_RST_CHKMODE = 8'h00;
    localparam int SLPEM_CHKMODE_BIT = 6;
    localparam int SLPEM_DENSITY_BIT = 7;
    localparam int SLPEM_SEL_LANE_LSB = 4;
    localparam int SLPEM_IRQ_CLR_BIT = 7;
    localparam int SLPEM_CNT_STOP_BIT = 6;
    localparam int SLPEM_CNT_CLR_BIT = 5;
    localparam logic [1:0] SLPEM_KIND_DISP = 2'h0;
    localparam logic [1:0] SLPEM_KIND_NIT = 2'h1;
    localparam logic [1:0] SLPEM_KIND_UCC = 2'h2;
    typedef enum logic [2:0] {
        SLPEM_H_IDLE = 3'b001,
        SLPEM_H_WRITE = 3'b010,
        SLPEM_H_READ = 3'b100
    } slpem_host_e;
endpackage
`default_nettype wire

// ---- tb.sv ----
/*
  Testbench joining host end and device end through the register port.
  Assumes a 40 MHz clock and the bench driving inputs at falling edges.
*/
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import slpem_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [11:0] req_addr = 12'h000;
    logic [7:0] req_wdata = 8'h00, disp_err = 8'h00, nit_err = 8'h00, ucc_err = 8'h00;
    logic req_busy, resp_valid, checksum_mode;
    logic [7:0] resp_data, lane_align_enable, disparity_irq;
    logic [4:0] samples_minus_one;
    int err_count = 0;
    int total_checks = 0;
    logic [11:0] rst_addr [8] = '{12'h459, 12'h45A, 12'h45B, 12'h45C, 12'h45D, 12'h46C,
        12'h46B, 12'h46D};
    logic [7:0] rst_val [8] = '{8'h20, 8'h80, 8'h00, 8'h00, 8'h45, 8'h0F, 8'h00, 8'h00};
    slpem_if slpem_if_i();
    slpem_host slpem_host_i(.clk_sys(clk_sys), .reset(reset), .bus(slpem_if_i),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_busy(req_busy), .resp_valid(resp_valid),
        .resp_data(resp_data));
    slpem_device #(.LANES(8)) slpem_device_i(.clk_sys(clk_sys), .reset(reset),
        .bus(slpem_if_i), .disp_err(disp_err), .nit_err(nit_err), .ucc_err(ucc_err),
        .lane_align_enable(lane_align_enable), .disparity_irq(disparity_irq),
        .checksum_mode(checksum_mode), .samples_minus_one(samples_minus_one));
    slpem_checker slpem_checker_i(.clk_sys(clk_sys), .reset(reset),
        .wr_en(slpem_if_i.wr_en), .rd_en(slpem_if_i.rd_en), .addr(slpem_if_i.addr),
        .wdata(slpem_if_i.wdata), .rdata(slpem_if_i.rdata), .rvalid(slpem_if_i.rvalid));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bus_op(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 0;
        while ((wr ? req_busy !== 1'b0 : resp_valid !== 1'b1) && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20) check("handshake", 8'h00, 8'h01);
        q = resp_data;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus_op(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus_op(1'b0, a, 8'h00, q);
        check(name, q, exp);
    endtask
    task automatic sel_chk(input logic [2:0] lane, input logic [1:0] kind, input logic [7:0] exp);
        wr(SLPEM_ADDR_ERRMON, {1'b0, lane, 2'b00, kind});
        rd_chk("error count", SLPEM_ADDR_ERRMON, exp);
    endtask
    task automatic pulse(input logic [7:0] d, input logic [7:0] n, input logic [7:0] u, int c);
        @(negedge clk_sys);
        disp_err = d;
        nit_err = n;
        ucc_err = u;
        repeat (c) @(negedge clk_sys);
        disp_err = 8'h00;
        nit_err = 8'h00;
        ucc_err = 8'h00;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        check("deskew out", lane_align_enable, 8'h0F);
        check("samples out", {3'b000, samples_minus_one}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset value", rst_addr[i], rst_val[i]);
        end
        wr(SLPEM_ADDR_DENSITY, SLPEM_RST_DENSITY);
        rd_chk("density", SLPEM_ADDR_DENSITY, 8'h80);
        wr(SLPEM_ADDR_SAMPLES, 8'h21);
        check("samples out", {3'b000, samples_minus_one}, 8'h01);
        rd_chk("samples", SLPEM_ADDR_SAMPLES, 8'h21);
        wr(SLPEM_ADDR_CHECKSUM, 8'h3C);
        rd_chk("checksum", SLPEM_ADDR_CHECKSUM, 8'h3C);
        wr(SLPEM_ADDR_CHKMODE, 8'h40);
        check("checksum mode", {7'h00, checksum_mode}, 8'h01);
        rd_chk("checksum mode reg", SLPEM_ADDR_CHKMODE, 8'h40);
        wr(SLPEM_ADDR_DESKEW, 8'hA5);
        check("deskew out", lane_align_enable, 8'hA5);
        wr(12'h123, 8'hFF);
        rd_chk("unmapped", 12'h123, 8'h00);
        wr(SLPEM_ADDR_THRESHOLD, 8'h03);
        rd_chk("threshold", SLPEM_ADDR_THRESHOLD, 8'h03);
        pulse(8'h04, 8'h20, 8'h02, 3);
        pulse(8'h00, 8'h00, 8'h02, 1);
        sel_chk(3'd2, 2'h0, 8'h03);
        sel_chk(3'd5, 2'h1, 8'h03);
        sel_chk(3'd1, 2'h2, 8'h04);
        sel_chk(3'd5, 2'h0, 8'h00);
        sel_chk(3'd2, 2'h3, 8'h00);
        rd_chk("flags", SLPEM_ADDR_DISPARITY, 8'h04);
        check("irq out", disparity_irq, 8'h04);
        wr(SLPEM_ADDR_DISPARITY, 8'h02);
        rd_chk("flags", SLPEM_ADDR_DISPARITY, 8'h04);
        wr(SLPEM_ADDR_DISPARITY, 8'h22);
        sel_chk(3'd2, 2'h0, 8'h00);
        rd_chk("flags", SLPEM_ADDR_DISPARITY, 8'h04);
        wr(SLPEM_ADDR_DISPARITY, 8'h82);
        rd_chk("flags", SLPEM_ADDR_DISPARITY, 8'h00);
        wr(SLPEM_ADDR_DISPARITY, 8'h42);
        pulse(8'h05, 8'h00, 8'h00, 3);
        sel_chk(3'd2, 2'h0, 8'h00);
        rd_chk("flags", SLPEM_ADDR_DISPARITY, 8'h01);
        @(negedge clk_sys);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        check("deskew out", lane_align_enable, SLPEM_RST_DESKEW);
        check("samples out", {3'b000, samples_minus_one}, 8'h00);
        rd_chk("flags", SLPEM_ADDR_DISPARITY, 8'h00);
        sel_chk(3'd0, SLPEM_KIND_DISP, 8'h00);
        complete_run();
    end
    initial begin
        #500000;
        err_count++;
        complete_run();
    end
endmodule // tb
`default_nettype wire
